// ---- trace_pkg.sv ----
// shared constants and helpers for the trace capture link
// Overview of operation
// RULE_01 - buffer mode: newest entry replaces oldest
// RULE_02 - buffer readout served only while target halted
// RULE_03 - stream mode drains buffer while it fills
// RULE_04 - data lines sampled by target's trace clock
// RULE_05 - up to four lines, width setting defaults four
// RULE_06 - one sample per trace clock edge
// RULE_07 - target trace clock is half cpu clock
// RULE_08 - four lines: two nibbles form one byte
// RULE_09 - capture works at 100 MHz or more
// RULE_10 - per-line adjustable sampling delay
// RULE_11 - on-chip buffer read over debug interface
// RULE_12 - no streaming with on-chip buffer source
// RULE_13 - source defaults to pins until host selects
// RULE_14 - reset clears pointers, capture idle until enabled
`default_nettype none
package trace_pkg;
	// link and storage shape
	localparam int LINES = 4;
	localparam int DEPTH = 16;
	localparam int IDX_W = 4;
	localparam int PTR_W = 5;
	localparam logic [PTR_W-1:0] FULL_GAP = 5'h10;
	localparam logic [IDX_W-1:0] IDX_LAST = 4'hF;
	// clock figures
	localparam int CLK_MHZ = 50;
	localparam int TRACE_MIN_MHZ = 100;
	localparam int TRACE_DIV = 2;
	// register byte offsets
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_STATUS = 4'h4;
	localparam logic [3:0] ADR_DATA = 4'h8;
	localparam logic [3:0] ADR_CHIP = 4'hC;
	// control fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_STREAM = 1;
	localparam int CTRL_SRC = 2;
	localparam int CTRL_WID = 3;
	localparam int CTRL_DLY = 8;
	localparam logic [15:0] CTRL_RESET = 16'h0010;
	localparam logic [1:0] WID_ONE = 2'h0;
	localparam logic [1:0] WID_TWO = 2'h1;
	localparam logic [1:0] WID_FOUR = 2'h2;
	// status, data and on-chip read fields
	localparam int STAT_CNT = 0;
	localparam int STAT_HALT = 8;
	localparam int STAT_OVF = 9;
	localparam int STAT_WRAP = 10;
	localparam int STAT_STREAM = 11;
	localparam int DATA_VLD = 8;
	localparam int CHIP_BUSY = 8;
	localparam int CHIP_DONE = 9;

	function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b[PTR_W-1] = g[PTR_W-1];
		for (int i = PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : gray2bin
endpackage : trace_pkg
`default_nettype wire

// ---- trace_if.sv ----
// trace pins and debug access between target and probe
`default_nettype none
interface trace_if import trace_pkg::*; ();
	logic trace_clk;
	logic [LINES-1:0] trace_data;
	logic halted;
	logic src_onchip;
	logic dbg_req;
	logic [IDX_W-1:0] dbg_idx;
	logic dbg_ack;
	logic [7:0] dbg_data;

	modport target_end(
		output trace_clk, trace_data, halted, dbg_ack, dbg_data,
		input src_onchip, dbg_req, dbg_idx
	);
	modport probe_end(
		input trace_clk, trace_data, halted, dbg_ack, dbg_data,
		output src_onchip, dbg_req, dbg_idx
	);
endinterface : trace_if
`default_nettype wire

// ---- sync2.sv ----
// two flip-flop synchroniser with asynchronous clear
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	input wire logic clk_i, // destination clock
	input wire logic rst_i, // clear, active high
	input wire logic [W-1:0] d_i, // source-domain value
	output logic [W-1:0] q_o // synchronised value
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule : sync2
`default_nettype wire

// ---- trace_target.sv ----
// target-side trace unit: drives ddr trace pins and serves on-chip buffer reads
`default_nettype none
module trace_target import trace_pkg::*; (
	input wire logic clk_i, // cpu clock
	input wire logic rst_i, // synchronous reset
	input wire logic [7:0] byte_i, // trace byte to send
	input wire logic byte_valid_i, // byte offered
	output logic byte_ready_o, // byte accepted when valid
	input wire logic halted_i, // cpu halted level
	trace_if.target_end link // trace pins and debug access
);
	logic src_s;
	logic req_s;
	logic ph;
	logic tclk;
	logic [LINES-1:0] pins;
	logic [3:0] hi_nib;
	logic halted_q;
	logic ack;
	logic [7:0] dbg_q;
	logic [7:0] chip [DEPTH];
	logic [IDX_W-1:0] cidx;
	logic take;
	logic next_ph;

	sync2 #(.W(1)) u_src (.clk_i(clk_i), .rst_i(rst_i), .d_i(link.src_onchip), .q_o(src_s));
	sync2 #(.W(1)) u_req (.clk_i(clk_i), .rst_i(rst_i), .d_i(link.dbg_req), .q_o(req_s));

	// handshake and phase decode
	assign take = byte_valid_i & byte_ready_o;
	assign next_ph = ph ? 1'b0 : (take & ~src_s);

	// RULE_06 nibble per edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph <= 1'b0;
			pins <= '0;
			hi_nib <= '0;
			byte_ready_o <= 1'b0;
		end else begin
			ph <= next_ph;
			byte_ready_o <= ~next_ph;
			if (ph) begin
				pins <= hi_nib;
			end else if (take && !src_s) begin
				pins <= byte_i[3:0];
				hi_nib <= byte_i[7:4];
			end
		end
	end

	// RULE_07 half-rate clock
	// toggled mid-cycle so every nibble is centred on its edge
	always_ff @(negedge clk_i) begin
		if (rst_i) begin
			tclk <= 1'b0;
		end else begin
			tclk <= ph;
		end
	end

	// on-chip store and debug read service
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cidx <= '0;
			ack <= 1'b0;
			dbg_q <= '0;
			halted_q <= 1'b0;
		end else begin
			halted_q <= halted_i;
			if (take && src_s) begin
				cidx <= cidx + 4'h1;
			end
			if (req_s && !ack) begin
				dbg_q <= chip[link.dbg_idx];
				ack <= 1'b1;
			end else if (!req_s) begin
				ack <= 1'b0;
			end
		end
	end

	// on-chip buffer storage
	always_ff @(posedge clk_i) begin
		if (take && src_s) begin
			chip[cidx] <= byte_i;
		end
	end

	assign link.trace_clk = tclk;
	assign link.trace_data = pins;
	assign link.halted = halted_q;
	assign link.dbg_ack = ack;
	assign link.dbg_data = dbg_q;
endmodule : trace_target
`default_nettype wire

// ---- trace_probe.sv ----
// probe-side trace capture: ddr sampling, circular buffer, wishbone registers
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`default_nettype none
module trace_probe import trace_pkg::*; (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [3:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	trace_if.probe_end link // trace pins and debug access
);
	// system-domain state
	logic [15:0] ctrl;
	logic link_rst;
	logic [PTR_W-1:0] rbin;
	logic [PTR_W-1:0] rgray;
	logic [PTR_W-1:0] rd_cnt;
	logic req;
	logic [IDX_W-1:0] req_idx;
	logic [7:0] chip_data;
	logic chip_done;
	logic src_q;
	// link-domain state
	logic [LINES-1:0] rise_q;
	logic [1:0] beat;
	logic [7:0] acc;
	logic [PTR_W-1:0] wbin;
	logic [PTR_W-1:0] wgray;
	logic ovf;
	logic wrapped;
	logic [7:0] mem [DEPTH];
	// crossings
	logic [PTR_W-1:0] wgray_s;
	logic [1:0] flags_s;
	logic halted_s;
	logic ack_s;
	logic [PTR_W-1:0] rgray_l;
	logic link_clk_n;

	// configuration decode
	logic en;
	logic stream_eff;
	logic [1:0] wid;
	assign en = ctrl[CTRL_EN];
	// RULE_12 no stream on-chip
	assign stream_eff = ctrl[CTRL_STREAM] & ~ctrl[CTRL_SRC];
	// RULE_05 width setting
	assign wid = ctrl[CTRL_WID +: 2];
	assign link_clk_n = ~link.trace_clk;

	// RULE_14 capture held idle
	// link logic stays cleared until enabled, so config is static there
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_rst <= 1'b1;
		end else begin
			link_rst <= ~en;
		end
	end

	// RULE_04 sampled by trace clock
	// RULE_09 no system clock in path
	always_ff @(posedge link.trace_clk or posedge link_rst) begin
		if (link_rst) begin
			rise_q <= '0;
		end else begin
			rise_q <= link.trace_data;
		end
	end

	// RULE_10 per-line sample delay
	logic [LINES-1:0] dly_r;
	logic [LINES-1:0] dly_f;
	for (genvar l = 0; l < LINES; l++) begin : g_line
		logic [1:0] cur;
		logic [1:0] h0;
		logic [1:0] h1;
		logic [1:0] h2;
		logic [1:0] dsel;
		logic [1:0] pick;
		assign cur = {link.trace_data[l], rise_q[l]};
		assign dsel = ctrl[CTRL_DLY + 2*l +: 2];
		assign pick = (dsel == 2'h0) ? cur : (dsel == 2'h1) ? h0 : (dsel == 2'h2) ? h1 : h2;
		assign dly_f[l] = pick[1];
		assign dly_r[l] = pick[0];
		// history of edge pairs for this line
		always_ff @(negedge link.trace_clk or posedge link_rst) begin
			if (link_rst) begin
				h0 <= '0;
				h1 <= '0;
				h2 <= '0;
			end else begin
				h0 <= cur;
				h1 <= h0;
				h2 <= h1;
			end
		end
	end

	// RULE_08 nibbles into byte
	// rising-edge sample is the low half of each chunk
	logic [7:0] next_acc;
	logic [1:0] last;
	logic done;
	assign next_acc = (wid == WID_FOUR) ? {dly_f, dly_r} :
		(wid == WID_TWO) ? {dly_f[1:0], dly_r[1:0], acc[7:4]} :
		{dly_f[0], dly_r[0], acc[7:2]};
	assign last = (wid == WID_FOUR) ? 2'h0 : (wid == WID_TWO) ? 2'h1 : 2'h3;
	assign done = (beat == last);

	// write-side pointer decode
	logic [PTR_W-1:0] rbin_l;
	logic [PTR_W-1:0] gap;
	logic [PTR_W-1:0] next_wbin;
	logic drop;
	assign rbin_l = gray2bin(rgray_l);
	assign gap = wbin - rbin_l;
	assign next_wbin = wbin + 5'h01;
	// RULE_03 stream stops only at full
	assign drop = stream_eff & (gap == FULL_GAP);

	// RULE_06 byte completes on falling edge
	always_ff @(negedge link.trace_clk or posedge link_rst) begin
		if (link_rst) begin
			beat <= '0;
			acc <= '0;
			wbin <= '0;
			wgray <= '0;
			ovf <= 1'b0;
			wrapped <= 1'b0;
		end else begin
			acc <= next_acc;
			beat <= done ? 2'h0 : beat + 2'h1;
			if (done && drop) begin
				ovf <= 1'b1;
			end
			if (done && !drop) begin
				wbin <= next_wbin;
				wgray <= bin2gray(next_wbin);
			end
			// RULE_01 overwrite oldest once full
			if (done && !stream_eff && wbin[IDX_W-1:0] == IDX_LAST) begin
				wrapped <= 1'b1;
			end
		end
	end

	// capture storage, written only in the link domain
	always_ff @(negedge link.trace_clk) begin
		if (done && !drop) begin
			mem[wbin[IDX_W-1:0]] <= next_acc;
		end
	end

	sync2 #(.W(PTR_W)) u_rsync (.clk_i(link_clk_n), .rst_i(link_rst), .d_i(rgray), .q_o(rgray_l));
	sync2 #(.W(PTR_W)) u_wsync (.clk_i(clk_i), .rst_i(rst_i), .d_i(wgray), .q_o(wgray_s));
	sync2 #(.W(2)) u_fsync (.clk_i(clk_i), .rst_i(rst_i), .d_i({wrapped, ovf}), .q_o(flags_s));
	sync2 #(.W(1)) u_hsync (.clk_i(clk_i), .rst_i(rst_i), .d_i(link.halted), .q_o(halted_s));
	sync2 #(.W(1)) u_async (.clk_i(clk_i), .rst_i(rst_i), .d_i(link.dbg_ack), .q_o(ack_s));

	// read-side decode
	logic [PTR_W-1:0] wbin_s;
	logic wrapped_s;
	logic [PTR_W-1:0] fill;
	logic [IDX_W-1:0] oldest;
	logic buf_avail;
	logic rd_avail;
	logic [IDX_W-1:0] rd_idx;
	logic [PTR_W-1:0] cnt;
	assign wbin_s = gray2bin(wgray_s);
	assign wrapped_s = flags_s[1];
	assign fill = wrapped_s ? FULL_GAP : wbin_s;
	assign oldest = wrapped_s ? wbin_s[IDX_W-1:0] : '0;
	// RULE_02 readout only when halted
	assign buf_avail = halted_s & (rd_cnt != fill);
	// RULE_03 stream drains while filling
	assign rd_avail = stream_eff ? (rbin != wbin_s) : buf_avail;
	assign rd_idx = stream_eff ? rbin[IDX_W-1:0] : oldest + rd_cnt[IDX_W-1:0];
	assign cnt = stream_eff ? wbin_s - rbin : fill - rd_cnt;

	// bus decode
	logic take;
	logic wr;
	logic sel_ctrl;
	logic sel_stat;
	logic sel_data;
	logic sel_chip;
	logic pop;
	logic chip_busy;
	logic chip_start;
	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = take & wb_we_i;
	assign sel_ctrl = (wb_adr_i == ADR_CTRL);
	assign sel_stat = (wb_adr_i == ADR_STATUS);
	assign sel_data = (wb_adr_i == ADR_DATA);
	assign sel_chip = (wb_adr_i == ADR_CHIP);
	assign pop = take & ~wb_we_i & sel_data & rd_avail;
	assign chip_busy = req | ack_s;
	// RULE_11 on-chip read via debug
	assign chip_start = wr & sel_chip & wb_sel_i[0] & ctrl[CTRL_SRC] & ~chip_busy;

	// status and read data packing
	logic [31:0] status;
	logic [31:0] next_rdata;
	always_comb begin
		status = '0;
		status[STAT_CNT +: PTR_W] = cnt;
		status[STAT_HALT] = halted_s;
		status[STAT_OVF] = flags_s[0];
		status[STAT_WRAP] = wrapped_s;
		status[STAT_STREAM] = stream_eff;
		next_rdata = '0;
		if (sel_ctrl) begin
			next_rdata[15:0] = ctrl;
		end else if (sel_stat) begin
			next_rdata = status;
		end else if (sel_data) begin
			next_rdata[7:0] = rd_avail ? mem[rd_idx] : 8'h00;
			next_rdata[DATA_VLD] = rd_avail;
		end else if (sel_chip) begin
			next_rdata[7:0] = chip_data;
			next_rdata[CHIP_BUSY] = chip_busy;
			next_rdata[CHIP_DONE] = chip_done;
		end
	end

	// control register: only the enable bit may change while enabled
	// RULE_13 pins source by default
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RESET;
		end else if (wr && sel_ctrl) begin
			if (wb_sel_i[0] && en) begin
				ctrl[CTRL_EN] <= wb_dat_i[CTRL_EN];
			end else if (wb_sel_i[0]) begin
				ctrl[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1] && !en) begin
				ctrl[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// read pointers; buffer readout restarts each halt
	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			rd_cnt <= '0;
			rbin <= '0;
			rgray <= '0;
		end else begin
			if (!halted_s) begin
				rd_cnt <= '0;
			end else if (pop && !stream_eff) begin
				rd_cnt <= rd_cnt + 5'h01;
			end
			if (pop && stream_eff) begin
				rbin <= rbin + 5'h01;
				rgray <= bin2gray(rbin + 5'h01);
			end
		end
	end

	// RULE_11 four-phase debug read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req <= 1'b0;
			req_idx <= '0;
			chip_data <= '0;
			chip_done <= 1'b0;
			src_q <= 1'b0;
		end else begin
			src_q <= ctrl[CTRL_SRC];
			if (chip_start) begin
				req <= 1'b1;
				req_idx <= wb_dat_i[IDX_W-1:0];
				chip_done <= 1'b0;
			end else if (req && ack_s) begin
				req <= 1'b0;
				chip_data <= link.dbg_data;
				chip_done <= 1'b1;
			end
		end
	end

	// wishbone answer one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= take;
			if (take) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	assign link.src_onchip = src_q;
	assign link.dbg_req = req;
	assign link.dbg_idx = req_idx;
endmodule : trace_probe
`default_nettype wire

// ---- trace_port_capture_assertions.sv ----
// concurrent checks on the trace link between target and probe
`default_nettype none
module trace_port_capture_assertions import trace_pkg::*; (
	input wire logic clk_i, // probe clock
	input wire logic rst_i, // probe reset
	input wire logic cpu_clk_i, // target clock
	input wire logic cpu_rst_i, // target reset
	input wire logic trace_clk, // trace clock
	input wire logic src_onchip, // source select
	input wire logic dbg_req, // debug read request
	input wire logic [IDX_W-1:0] dbg_idx, // debug read index
	input wire logic dbg_ack, // debug read answer
	input wire logic [7:0] dbg_data // debug read data
);
	// probe side of the debug read and the source select
	reset_idle_a: assert property (
		@(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> !src_onchip && !dbg_req)
		else $error("source or request not idle after reset");
	req_source_a: assert property (
		@(posedge clk_i) disable iff (rst_i) $rose(dbg_req) |-> src_onchip)
		else $error("debug read without on-chip source");
	idx_stable_a: assert property (
		@(posedge clk_i) disable iff (rst_i) dbg_req && $past(dbg_req) |-> $stable(dbg_idx))
		else $error("index changed during request");
	req_answer_a: assert property (
		@(posedge clk_i) disable iff (rst_i) $rose(dbg_req) |-> ##[1:40] dbg_ack)
		else $error("debug read not answered");
	ack_release_a: assert property (
		@(posedge clk_i) disable iff (rst_i) $fell(dbg_req) |-> ##[1:40] !dbg_ack)
		else $error("answer not withdrawn");
	// target side: answer and pin timing
	ack_needs_req_a: assert property (
		@(posedge cpu_clk_i) disable iff (cpu_rst_i) $rose(dbg_ack) |-> dbg_req)
		else $error("answer without request");
	data_stable_a: assert property (
		@(posedge cpu_clk_i) disable iff (cpu_rst_i)
		dbg_ack && $past(dbg_ack) |-> $stable(dbg_data))
		else $error("answer data changed");
	clk_pair_a: assert property (
		@(posedge cpu_clk_i) disable iff (cpu_rst_i) $rose(trace_clk) |=> $fell(trace_clk))
		else $error("trace clock period not whole");
endmodule : trace_port_capture_assertions
`default_nettype wire

// ---- trace_port_capture_tb.sv ----
// self-checking bench: probe and target joined by the trace link
`default_nettype none
module trace_port_capture_tb import trace_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, cpu_clk, rst_i, cyc, stb, we, halted, valid, ack, ready;
	logic [3:0] adr;
	logic [31:0] wdat, rdat, dat_o;
	logic [7:0] tbyte;
	int mismatches, total_checks;
	trace_if link_if();
	trace_target i_trace_target (.clk_i(cpu_clk), .rst_i(rst_i), .byte_i(tbyte),
		.byte_valid_i(valid), .byte_ready_o(ready), .halted_i(halted), .link(link_if));
	trace_probe i_trace_probe (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .link(link_if));
	trace_port_capture_assertions i_trace_port_capture_assertions (.clk_i(clk_i),
		.rst_i(rst_i), .cpu_clk_i(cpu_clk), .cpu_rst_i(rst_i), .trace_clk(link_if.trace_clk),
		.src_onchip(link_if.src_onchip), .dbg_req(link_if.dbg_req), .dbg_idx(link_if.dbg_idx),
		.dbg_ack(link_if.dbg_ack), .dbg_data(link_if.dbg_data));
	// system clock and unrelated target clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		cpu_clk = 1'b0;
		#1.7;
		forever #3 cpu_clk = ~cpu_clk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// one classic bus cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0000_0000);
		check(name, exp, rdat);
	endtask : rd_chk
	// offer one byte to the target trace unit
	task automatic send(input logic [7:0] b);
		@(posedge cpu_clk);
		tbyte <= b;
		valid <= 1'b1;
		do @(posedge cpu_clk); while (ready !== 1'b1);
		valid <= 1'b0;
	endtask : send
	task automatic settle();
		repeat (10) @(posedge clk_i);
	endtask : settle
	initial begin
		#200_000;
		mismatches++;
		stop_test();
	end
	initial begin
		{cyc, stb, we, halted, valid} = 5'h00;
		rst_i = 1'b1;
		adr = 4'h0;
		wdat = 32'h0000_0000;
		tbyte = 8'h00;
		mismatches = 0;
		total_checks = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset state: pins source, width four, idle
		rd_chk("ctrl", ADR_CTRL, 32'h0000_0010);
		rd_chk("status", ADR_STATUS, 32'h0000_0000);
		check("source", 32'h0000_0000, {31'h0000_0000, link_if.src_onchip});
		$display("test reset done");
		// streaming: bytes assembled from nibble pairs, overflow at sixteen unread
		wb(1'b1, ADR_CTRL, 32'h0000_0013);
		for (int i = 0; i < 4; i++) send(8'hA0 + i[7:0]);
		settle();
		rd_chk("stream status", ADR_STATUS, 32'h0000_0804);
		for (int i = 0; i < 4; i++) rd_chk("stream data", ADR_DATA, 32'h0000_01A0 + i);
		for (int i = 0; i < 17; i++) send(8'h50 + i[7:0]);
		settle();
		rd_chk("overflow status", ADR_STATUS, 32'h0000_0A10);
		for (int i = 0; i < 16; i++) rd_chk("drain data", ADR_DATA, 32'h0000_0150 + i);
		rd_chk("drained status", ADR_STATUS, 32'h0000_0A00);
		wb(1'b1, ADR_CTRL, 32'h0000_0000);
		$display("test stream done");
		// narrow port widths rebuild bytes over several periods
		wb(1'b1, ADR_CTRL, 32'h0000_000B);
		send(8'h31);
		send(8'h02);
		settle();
		rd_chk("two line data", ADR_DATA, 32'h0000_012D);
		wb(1'b1, ADR_CTRL, 32'h0000_0000);
		wb(1'b1, ADR_CTRL, 32'h0000_0003);
		send(8'h01);
		send(8'h10);
		send(8'h11);
		send(8'h00);
		settle();
		rd_chk("one line data", ADR_DATA, 32'h0000_0139);
		wb(1'b1, ADR_CTRL, 32'h0000_0000);
		// one period of sample delay on every line shifts the bytes by one
		wb(1'b1, ADR_CTRL, 32'h0000_5513);
		send(8'h96);
		send(8'h3C);
		settle();
		rd_chk("delayed first", ADR_DATA, 32'h0000_0100);
		rd_chk("delayed second", ADR_DATA, 32'h0000_0196);
		wb(1'b1, ADR_CTRL, 32'h0000_0000);
		$display("test width done");
		// circular buffer, read only while halted
		wb(1'b1, ADR_CTRL, 32'h0000_0011);
		for (int i = 0; i < 20; i++) send(8'h40 + i[7:0]);
		settle();
		wb(1'b0, ADR_DATA, 32'h0000_0000);
		check("running valid", 32'h0000_0000, {31'h0000_0000, rdat[DATA_VLD]});
		halted <= 1'b1;
		settle();
		rd_chk("halted status", ADR_STATUS, 32'h0000_0510);
		for (int i = 0; i < 16; i++) rd_chk("buffer data", ADR_DATA, 32'h0000_0144 + i);
		halted <= 1'b0;
		wb(1'b1, ADR_CTRL, 32'h0000_0000);
		$display("test buffer done");
		// on-chip source: no streaming, read back over debug access
		wb(1'b1, ADR_CTRL, 32'h0000_0016);
		settle();
		check("source", 32'h0000_0001, {31'h0000_0000, link_if.src_onchip});
		for (int i = 0; i < 16; i++) send(8'h70 + i[7:0]);
		wb(1'b1, ADR_CTRL, 32'h0000_0017);
		wb(1'b0, ADR_STATUS, 32'h0000_0000);
		check("stream offered", 32'h0000_0000, {31'h0000_0000, rdat[STAT_STREAM]});
		wb(1'b1, ADR_CHIP, 32'h0000_0005);
		rdat = 32'h0000_0000;
		// busy outlives done until the withdrawn answer has crossed back
		for (int i = 0; i < 40 && {rdat[CHIP_DONE], rdat[CHIP_BUSY]} !== 2'h2; i++) begin
			wb(1'b0, ADR_CHIP, 32'h0000_0000);
		end
		check("chip data", 32'h0000_0275, rdat);
		$display("test onchip done");
		stop_test();
	end
endmodule : trace_port_capture_tb
`default_nettype wire
